//--- sim/dram_mode_reg_feature_ctrl_bench.sv
// Self-checking bench for the mode register feature control block
`timescale 1ns/1ps
module dram_mode_reg_feature_ctrl_bench;
	logic core_clk = 0, rst = 1, crc_error_event = 0, multipurpose_readout = 0, power_down = 0;
	logic on_die_termination_input = 0, gear_down = 0, cmd_valid, act_n, ras_n, cas_n, we_n;
	logic command_parity_bit, cmd_accept, cmd_reject, parity_error, crc_error;
	logic [1:0]  rej;
	logic read_inversion_active, write_inversion_active, write_byte_mask_active;
	logic nominal_termination_on, parity_latency_bad, gap_code_reserved, calibration_enable;
	logic calibration_range, reference_on_dq;
	logic [1:0]  bg, ba;
	logic [2:0]  parity_latency, parked_termination;
	logic [3:0]  same_group_column_gap;
	logic [5:0]  data_input_reference;
	logic [17:0] addr;
	int          errors = 0, checked = 0;
	// Expected gap beside each word; bits 21, 17 and equalisation stay zero, calibration on
	logic [25:0] rows [8] = '{{4'h4, 22'h18_0080}, {4'h5, 22'h18_04c1}, {4'h6, 22'h18_0882},
		{4'h7, 22'h18_0cc3}, {4'h8, 22'h18_1084}, {4'h4, 22'h18_14c5}, {4'h4, 22'h18_1886},
		{4'h4, 22'h18_1cff}};
	always #2.5 core_clk = ~core_clk;
	dram_mode_reg_feature_ctrl i_dram_mode_reg_feature_ctrl (.core_clk, .rst, .cmd_valid, .act_n,
		.ras_n, .cas_n, .we_n, .bg, .ba, .addr, .command_parity_bit, .crc_error_event,
		.multipurpose_readout, .power_down, .on_die_termination_input, .gear_down, .cmd_accept,
		.cmd_reject, .parity_error, .crc_error, .read_inversion_active, .write_inversion_active,
		.write_byte_mask_active, .nominal_termination_on, .parked_termination,
		.parity_latency, .parity_latency_bad, .same_group_column_gap, .gap_code_reserved,
		.calibration_enable, .calibration_range, .data_input_reference, .reference_on_dq);
	mrs_driver i_mrs_driver (.core_clk, .cmd_valid, .act_n, .ras_n, .cas_n, .we_n,
		.command_parity_bit, .bg, .ba, .addr);
	task chk(input string n, input logic [21:0] e, input logic [21:0] g);
		checked++;
		if (g !== e) begin
			errors++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	task wr(input logic [21:0] w, input logic bad);
		i_mrs_driver.send(w, bad);
		rej = {cmd_reject, cmd_accept};
		i_mrs_driver.idle();
	endtask
	task stop_test();
		if (errors == 0 && checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		#5000;
		errors++;
		stop_test();
	end
	initial begin
		repeat (16) @(posedge core_clk);
		rst <= 1'b0;
		chk("latency", 3'h0, parity_latency);
		for (int i = 0; i < 8; i++) begin
			wr(rows[i][21:0], 1'b0);
			chk("gap", rows[i][25:22], same_group_column_gap);
			chk("reserved", rows[i][12:10] > 3'h4, gap_code_reserved);
			chk("reference", rows[i][7:0], {calibration_enable, calibration_range,
				data_input_reference});
			chk("reference on", rows[i][7], reference_on_dq);
		end
		wr(22'h14_1001, 1'b0);
		chk("latency", 3'h4, parity_latency);
		chk("read inversion", 1'b1, read_inversion_active);
		@(posedge core_clk) multipurpose_readout <= 1'b1;
		#1 chk("readout inversion", 1'b0, read_inversion_active);
		wr(22'h14_0401, 1'b0);
		chk("mask", 2'h2, {write_byte_mask_active, write_inversion_active});
		wr(22'h14_0801, 1'b0);
		chk("inversion", 2'h1, {write_byte_mask_active, write_inversion_active});
		wr(22'h18_0885, 1'b1);
		chk("fault", 4'hb, {rej, parity_error, same_group_column_gap == 4'h4});
		wr(22'h18_0885, 1'b1);
		chk("unchecked", 3'h3, {rej, same_group_column_gap == 4'h6});
		wr(22'h14_0201, 1'b0);
		chk("cleared", 1'b0, parity_error);
		wr(22'h18_0c85, 1'b1);
		wr(22'h18_0c85, 1'b1);
		chk("persistent", 4'hb, {rej, parity_error, same_group_column_gap == 4'h6});
		@(posedge core_clk) crc_error_event <= 1'b1;
		@(posedge core_clk) crc_error_event <= 1'b0;
		repeat (3) @(posedge core_clk);
		#1 chk("crc", 1'b1, crc_error);
		wr(22'h14_0000, 1'b0);
		chk("flags", 2'h0, {crc_error, parity_error});
		wr(22'h1c_0885, 1'b0);
		chk("select seven", 4'h6, same_group_column_gap);
		@(posedge core_clk) gear_down <= 1'b1;
		wr(22'h14_0022, 1'b0);
		chk("gear", 4'hb, {parity_latency, parity_latency_bad});
		@(posedge core_clk) {power_down, on_die_termination_input} <= 2'h3;
		#1 chk("termination", 1'b0, nominal_termination_on);
		wr(22'h14_0140, 1'b0);
		chk("parked", 4'hd, {nominal_termination_on, parked_termination});
		@(posedge core_clk) rst <= 1'b1;
		@(posedge core_clk) rst <= 1'b0;
		#1 chk("reset", 12'h004, {crc_error, parity_error, parity_latency, parked_termination,
			same_group_column_gap});
		stop_test();
	end
endmodule

//--- sim/mode_feature_sva.sv
// Checker for the mode register feature control ports
`timescale 1ns/1ps
module mode_feature_sva (
	input wire logic        core_clk, rst, cmd_valid, act_n, ras_n, cas_n, we_n, crc_error_event,
	input wire logic        multipurpose_readout, gear_down, cmd_accept, cmd_reject, parity_error,
	input wire logic        crc_error, read_inversion_active, write_inversion_active,
	input wire logic        write_byte_mask_active, parity_latency_bad, gap_code_reserved,
	input wire logic        calibration_enable,
	input wire logic [1:0]  bg, ba,
	input wire logic [2:0]  parity_latency,
	input wire logic [3:0]  same_group_column_gap,
	input wire logic [5:0]  data_input_reference,
	input wire logic [17:0] addr
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	logic       cmd, w5, w6;
	logic [2:0] sel;
	assign cmd = cmd_valid & act_n & ~ras_n & ~cas_n & ~we_n;
	assign sel = {bg[0], ba};
	assign w5 = cmd & cmd_accept & (sel == 3'h5);
	assign w6 = cmd & cmd_accept & (sel == 3'h6);
	a_flag_set: assert property (cmd_reject |=> parity_error) else $error("flag unset");
	a_flag_hold: assert property (parity_error && !w5 |=> parity_error) else $error("lost");
	a_crc_set: assert property (crc_error_event |=> crc_error) else $error("crc unset");
	a_crc_hold: assert property (crc_error && !w5 |=> crc_error) else $error("crc lost");
	a_off_quiet: assert property (parity_latency == 3'h0 |-> !cmd_reject) else $error("chk");
	a_reject_excl: assert property (cmd_reject |-> !cmd_accept) else $error("both");
	a_readout_plain: assert property (multipurpose_readout |-> !read_inversion_active)
		else $error("inverted readout");
	a_mask_excl: assert property (write_byte_mask_active |-> !write_inversion_active)
		else $error("mask and inversion");
	a_gap_reserved: assert property (gap_code_reserved |-> same_group_column_gap == 4'h4)
		else $error("reserved gap");
	a_cal_load: assert property (w6 |=> calibration_enable == $past(addr[7]) &&
		data_input_reference == $past(addr[5:0])) else $error("calibration");
	a_dnu_ignored: assert property (cmd && sel == 3'h7 |=> $stable(same_group_column_gap))
		else $error("select 7 taken");
	a_gear_five: assert property (gear_down && parity_latency == 3'h5 |-> parity_latency_bad)
		else $error("latency 5");
	c_reject: cover property (cmd_reject);
	c_crc: cover property (crc_error_event ##1 crc_error);
	c_six: cover property (w6);
endmodule
bind dram_mode_reg_feature_ctrl mode_feature_sva i_mode_feature_sva (.core_clk, .rst, .cmd_valid,
	.act_n, .ras_n, .cas_n, .we_n, .crc_error_event, .multipurpose_readout, .gear_down,
	.cmd_accept, .cmd_reject, .parity_error, .crc_error, .read_inversion_active,
	.write_inversion_active, .write_byte_mask_active, .parity_latency_bad, .gap_code_reserved,
	.calibration_enable, .bg, .ba, .parity_latency, .same_group_column_gap,
	.data_input_reference, .addr);

//--- sim/mrs_driver.sv
// Controller model issuing mode register writes on the command pins
`timescale 1ns/1ps
module mrs_driver (
	input  wire logic   core_clk,
	output logic        cmd_valid, act_n, ras_n, cas_n, we_n, command_parity_bit,
	output logic [1:0]  bg, ba,
	output logic [17:0] addr
);
	initial {cmd_valid, act_n, ras_n, cas_n, we_n, command_parity_bit, bg, ba, addr} = '0;
	// Bits 16:14 go out as zero; bad flips parity on purpose
	task send(input logic [21:0] w, input logic bad);
		@(posedge core_clk);
		cmd_valid <= 1'b1;
		{act_n, ras_n, cas_n, we_n} <= 4'h8;
		{bg, ba} <= w[21:18];
		addr <= {w[17], 3'h0, w[13:0]};
		command_parity_bit <= ^{1'b1, w[21:17], w[13:0]} ^ bad;
		#1;
	endtask
	// Deselected lines toggle so a stale word never looks valid
	task idle();
		@(posedge core_clk);
		cmd_valid <= 1'b0;
		{act_n, ras_n, cas_n, we_n} <= 4'hf;
		addr <= ~addr;
		#1;
	endtask
endmodule

//--- verilog/dram_mode_reg_feature_ctrl.sv
// Mode register five/six feature control with parity and CRC status
`timescale 1ns/1ps

// Operation
// - Inversion only on x8/x16, shared pin
// - Multipurpose readout returns data without inversion
// - Masking acts on writes only, x8/x16
// - Non-persistent: checking stops while error set
// - Persistent: checking continues while error set
// - Buffer off: ignore input, no nominal termination
// - Parity error sets sticky flag, write clears
// - CRC error sets sticky flag, write clears
// - Parity off by default, on with latency
// - Command in parity error is not executed
// - Parity covers command and address lines only
// - Bits 12:10 set column gap 4..8 clocks
// - Column gap honoured, minimum four clocks
// - Bit 7 enable, bit 6 range, bits 5:0 value
// - Reference generated, optionally driven on low lanes
// - Five: bits 12..9 inversion, mask, persistent parity
// - Five: bit 5 buffer off, bits 4,3 status
// - Five: bits 2:0 parity latency 4/5/6
module dram_mode_reg_feature_ctrl #(
	parameter logic [1:0] ORG = mode_feature_pkg::ORG_X8
) (
	input  wire logic        core_clk,
	input  wire logic        rst,
	input  wire logic        cmd_valid,
	input  wire logic        act_n,
	input  wire logic        ras_n,
	input  wire logic        cas_n,
	input  wire logic        we_n,
	input  wire logic [1:0]  bg,
	input  wire logic [1:0]  ba,
	input  wire logic [17:0] addr,
	input  wire logic        command_parity_bit,
	input  wire logic        crc_error_event,
	input  wire logic        multipurpose_readout,
	input  wire logic        power_down,
	input  wire logic        on_die_termination_input,
	input  wire logic        gear_down,
	output logic             cmd_accept,
	output logic             cmd_reject,
	output logic             parity_error,
	output logic             crc_error,
	output logic             read_inversion_active,
	output logic             write_inversion_active,
	output logic             write_byte_mask_active,
	output logic             nominal_termination_on,
	output logic [2:0]       parked_termination,
	output logic [2:0]       parity_latency,
	output logic             parity_latency_bad,
	output logic [3:0]       same_group_column_gap,
	output logic             gap_code_reserved,
	output logic             calibration_enable,
	output logic             calibration_range,
	output logic [5:0]       data_input_reference,
	output logic             reference_on_dq
);
	import mode_feature_pkg::*;

	// ****************************************************************
	// Functions
	// ****************************************************************
	function automatic logic [2:0] pick3(input logic [21:0] w, input int lsb);
		pick3 = w[lsb +: 3];
	endfunction

	// Reserved latency codes read as zero clocks
	function automatic logic [2:0] latency_clocks(input logic [2:0] code);
		unique case (code)
			PL_OFF:  latency_clocks = 3'h0;
			PL_4:    latency_clocks = PL_CLK_4;
			PL_5:    latency_clocks = PL_CLK_5;
			PL_6:    latency_clocks = PL_CLK_6;
			default: latency_clocks = 3'h0;
		endcase
	endfunction

	// Only a real latency turns checking on, never a reserved code
	function automatic logic latency_valid(input logic [2:0] code);
		latency_valid = (code == PL_4) || (code == PL_5) || (code == PL_6);
	endfunction

	// Reserved gap codes fall back to the four-clock floor
	function automatic logic [3:0] gap_clocks(input logic [2:0] code);
		if (code > GAP_MAX) begin
			gap_clocks = GAP_BASE;
		end else begin
			gap_clocks = GAP_BASE + {1'b0, code};
		end
	endfunction

	// Even parity over every line the command bit covers
	function automatic logic cover_parity(input logic [3:0] cmd, input logic [17:0] a,
		input logic [1:0] bank, input logic [1:0] group);
		cover_parity = ^{cmd, a, bank, group};
	endfunction

	// Activate high, the other three command pins low
	function automatic logic is_mode_set(input logic [3:0] cmd);
		is_mode_set = (cmd == 4'h8);
	endfunction

	// ****************************************************************
	// Command decode and parity
	// ****************************************************************
	logic [21:0] word;
	logic        is_mrs;
	logic        par_calc;
	logic        par_on;
	logic        checking;
	logic        par_bad;
	logic [2:0]  sel;

	// Register bits 16:14 travel on the command pins, so the word holds them zero
	assign word = {bg, ba, addr[17], 3'h0, addr[13:0]};
	assign sel  = word[SEL_LSB +: 3];
	// Activate low would be a row open, so it must not load a register
	assign is_mrs = cmd_valid && is_mode_set({act_n, ras_n, cas_n, we_n});
	// CKE, termination input and chip select never enter the sum
	assign par_calc = cover_parity({act_n, ras_n, cas_n, we_n}, addr, ba, bg);

	logic [21:0] mr5;
	logic [21:0] mr6;
	logic [21:0] next_mr5;
	logic [21:0] next_mr6;
	logic        next_par_err;
	logic        next_crc_err;

	// ****************************************************************
	// Parity check
	// ****************************************************************
	// Reserved latency codes leave checking off, as the reset state does
	assign par_on   = latency_valid(pick3(mr5, F5_PL_LSB));
	// Persistent mode keeps checking while the flag is up
	assign checking = par_on && (mr5[F5_PERSIST] || !parity_error);
	assign par_bad  = cmd_valid && checking && (par_calc != command_parity_bit);
	assign cmd_accept = cmd_valid && !par_bad;
	assign cmd_reject = par_bad;

	// ****************************************************************
	// Mode register state
	// ****************************************************************
	logic write_five;
	logic write_six;

	// Select 111 is do-not-use and falls through both compares
	assign write_five = is_mrs && cmd_accept && sel == SEL_FIVE;
	assign write_six  = is_mrs && cmd_accept && sel == SEL_SIX;

	always_comb begin
		next_mr5 = mr5;
		next_mr6 = mr6;
		if (write_five) begin
			next_mr5 = word;
		end
		if (write_six) begin
			next_mr6 = word;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			mr5 <= MR5_RESET;
			mr6 <= MR6_RESET;
		end else begin
			mr5 <= next_mr5;
			mr6 <= next_mr6;
		end
	end

	// ****************************************************************
	// Sticky status flags
	// ****************************************************************
	always_comb begin
		next_par_err = parity_error;
		next_crc_err = crc_error;
		// Only a mode register five write may clear a flag
		if (write_five) begin
			next_par_err = word[F5_PAR_ERR];
			next_crc_err = word[F5_CRC_ERR];
		end
		// Set beats a clearing write in the same cycle
		if (par_bad) begin
			next_par_err = 1'b1;
		end
		if (crc_error_event) begin
			next_crc_err = 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			parity_error <= 1'b0;
			crc_error    <= 1'b0;
		end else begin
			parity_error <= next_par_err;
			crc_error    <= next_crc_err;
		end
	end

	// ****************************************************************
	// Feature outputs
	// ****************************************************************
	// Field outputs register the next register values, so they change
	// on the same edge as the register and never lag a write
	logic       wide_org;
	logic       read_inv_enable;
	logic       next_read_inv_enable;
	logic       next_write_inversion_active;
	logic       next_write_byte_mask_active;
	logic       term_pd_off;
	logic       next_term_pd_off;
	logic [2:0] next_parked_termination;
	logic [2:0] next_parity_latency;
	logic       latency_reserved;
	logic       next_latency_reserved;
	logic       latency_is_five;
	logic       next_latency_is_five;
	logic [3:0] next_same_group_column_gap;
	logic       next_gap_code_reserved;
	logic       next_calibration_enable;
	logic       next_calibration_range;
	logic [5:0] next_data_input_reference;
	logic       next_reference_on_dq;
	logic [2:0] next_latency_code;
	logic [2:0] next_gap_code;

	assign wide_org = (ORG == ORG_X8) || (ORG == ORG_X16);

	always_comb begin
		next_latency_code           = pick3(next_mr5, F5_PL_LSB);
		next_gap_code               = pick3(next_mr6, F6_GAP_LSB);
		next_read_inv_enable        = wide_org && next_mr5[F5_RD_INV];
		// Shared pin: masking wins if a bad controller enables both
		next_write_byte_mask_active = wide_org && next_mr5[F5_MASK];
		next_write_inversion_active = wide_org && next_mr5[F5_WR_INV]
			&& !next_mr5[F5_MASK];
		next_term_pd_off            = next_mr5[F5_ODT_PD_OFF];
		next_parked_termination     = pick3(next_mr5, F5_PARK_LSB);
		next_parity_latency         = latency_clocks(next_latency_code);
		next_latency_reserved       = next_latency_code > PL_6;
		next_latency_is_five        = next_latency_code == PL_5;
		next_same_group_column_gap  = gap_clocks(next_gap_code);
		next_gap_code_reserved      = next_gap_code > GAP_MAX;
		next_calibration_enable     = next_mr6[F6_CAL_EN];
		next_calibration_range      = next_mr6[F6_CAL_RANGE];
		next_data_input_reference   = next_mr6[F6_CAL_LSB +: 6];
		next_reference_on_dq        = next_mr6[F6_CAL_EN];
	end

	// Reset values match both registers cleared
	always_ff @(posedge core_clk) begin
		if (rst) begin
			read_inv_enable        <= 1'b0;
			write_inversion_active <= 1'b0;
			write_byte_mask_active <= 1'b0;
			term_pd_off            <= 1'b0;
			parked_termination     <= 3'h0;
			parity_latency         <= 3'h0;
			latency_reserved       <= 1'b0;
			latency_is_five        <= 1'b0;
			same_group_column_gap  <= GAP_BASE;
			gap_code_reserved      <= 1'b0;
			calibration_enable     <= 1'b0;
			calibration_range      <= 1'b0;
			data_input_reference   <= 6'h00;
			reference_on_dq        <= 1'b0;
		end else begin
			read_inv_enable        <= next_read_inv_enable;
			write_inversion_active <= next_write_inversion_active;
			write_byte_mask_active <= next_write_byte_mask_active;
			term_pd_off            <= next_term_pd_off;
			parked_termination     <= next_parked_termination;
			parity_latency         <= next_parity_latency;
			latency_reserved       <= next_latency_reserved;
			latency_is_five        <= next_latency_is_five;
			same_group_column_gap  <= next_same_group_column_gap;
			gap_code_reserved      <= next_gap_code_reserved;
			calibration_enable     <= next_calibration_enable;
			calibration_range      <= next_calibration_range;
			data_input_reference   <= next_data_input_reference;
			reference_on_dq        <= next_reference_on_dq;
		end
	end

	// ****************************************************************
	// Pin-gated outputs
	// ****************************************************************
	// Readout patterns must come back raw so training sees true data
	assign read_inversion_active = read_inv_enable && !multipurpose_readout;
	// Buffer off: the pin may float, so it is not looked at
	assign nominal_termination_on = on_die_termination_input
		&& !(power_down && term_pd_off);
	// Gear-down forbids the five-clock latency; flagged, not blocked
	assign parity_latency_bad = latency_reserved
		|| (gear_down && latency_is_five);
endmodule

//--- verilog/mode_feature_pkg.sv
// Constants for the mode register five/six feature control block
package mode_feature_pkg;
	// ****************************************************************
	// Mode register write word layout
	// ****************************************************************
	localparam int MR_WIDTH          = 22;
	localparam int SEL_LSB           = 18;
	localparam logic [2:0] SEL_FIVE  = 3'h5;
	localparam logic [2:0] SEL_SIX   = 3'h6;
	localparam logic [2:0] SEL_DNU   = 3'h7;
	// ****************************************************************
	// Mode register five fields
	// ****************************************************************
	localparam int F5_RD_INV         = 12;
	localparam int F5_WR_INV         = 11;
	localparam int F5_MASK           = 10;
	localparam int F5_PERSIST        = 9;
	localparam int F5_PARK_LSB       = 6;
	localparam int F5_ODT_PD_OFF     = 5;
	localparam int F5_PAR_ERR        = 4;
	localparam int F5_CRC_ERR        = 3;
	localparam int F5_PL_LSB         = 0;
	localparam logic [2:0] PL_OFF    = 3'h0;
	localparam logic [2:0] PL_4      = 3'h1;
	localparam logic [2:0] PL_5      = 3'h2;
	localparam logic [2:0] PL_6      = 3'h3;
	localparam logic [2:0] PL_CLK_4  = 3'h4;
	localparam logic [2:0] PL_CLK_5  = 3'h5;
	localparam logic [2:0] PL_CLK_6  = 3'h6;
	// ****************************************************************
	// Mode register six fields
	// ****************************************************************
	localparam int F6_GAP_LSB        = 10;
	localparam int F6_EQ_HI          = 13;
	localparam int F6_EQ_LSB         = 8;
	localparam int F6_CAL_EN         = 7;
	localparam int F6_CAL_RANGE      = 6;
	localparam int F6_CAL_LSB        = 0;
	localparam logic [2:0] GAP_MAX   = 3'h4;
	localparam logic [3:0] GAP_BASE  = 4'h4;
	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic [21:0] MR5_RESET = 22'h00_0000;
	localparam logic [21:0] MR6_RESET = 22'h00_0000;
	// ****************************************************************
	// Organisations
	// ****************************************************************
	localparam logic [1:0] ORG_X4    = 2'h0;
	localparam logic [1:0] ORG_X8    = 2'h1;
	localparam logic [1:0] ORG_X16   = 2'h2;
endpackage
